// >>> shared/nvac_pkg.sv
// Constants, types and decoding shared by the nonvolatile byte access control.
// Assumes a single 50 MHz core clock; all times are converted to cycles here.
package nvac_pkg;

   // Clock period and self-timed durations
   localparam int CLK_NS = 20;
   localparam int WRITE_US = 4000; // Erase plus program time per byte
   localparam int PWRT_US = 1000; // Power-up write lockout time
   localparam int WRITE_CYC = (WRITE_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int PWRT_CYC = (PWRT_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 18;
   localparam int TP_W = 22;

   // Register selects on the special function register port
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_KEY = 3'h1;
   localparam logic [2:0] REG_DATA = 3'h2;
   localparam logic [2:0] REG_INDEX = 3'h3;
   localparam logic [2:0] REG_FLAG2 = 3'h4;

   // Field positions in nv_access_control
   localparam int B_PGM = 7;
   localparam int B_CFG = 6;
   localparam int B_ROW = 4;
   localparam int B_ABORT = 3;
   localparam int B_PERMIT = 2;
   localparam int B_WTRIG = 1;
   localparam int B_RTRIG = 0;
   // Field position in peripheral_flag_reg_two
   localparam int B_DONE = 4;

   // Unlock key values and erased cell contents
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   // Reset values
   localparam logic RST_SEL = 1'b0;
   localparam logic RST_ABORT = 1'b1;
   localparam logic RST_PERMIT = 1'b0;

   // Access target, one-hot
   typedef enum logic [2:0] {
      TGT_DATA = 3'b001,
      TGT_PROG = 3'b010,
      TGT_CFG = 3'b100
   } nvac_target_e;

   // Unlock key sequence states, one-hot
   typedef enum logic [2:0] {
      KEY_IDLE = 3'b001,
      KEY_HALF = 3'b010,
      KEY_ARMED = 3'b100
   } nvac_key_e;

   // Decode the two select bits into the access target
   function automatic nvac_target_e nvac_target(input logic pgm, input logic cfg);
      if (cfg) begin
         return TGT_CFG;
      end
      return pgm ? TGT_PROG : TGT_DATA;
   endfunction : nvac_target

endpackage : nvac_pkg

// >>> core/nvac_cell_array.sv
// Byte-wide nonvolatile cell array with its self-timed erase-then-program timer.
// Assumes start only while idle; contents are not cleared by reset.
module nvac_cell_array import nvac_pkg::*; #(
   parameter int unsigned WRITE_CYCLES = WRITE_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic touch_array,
   input wire logic [7:0] wr_index,
   input wire logic [7:0] wr_byte,
   input wire logic [7:0] rd_index,
   output logic [7:0] rd_byte,
   output logic done
);

   localparam logic [CNT_W-1:0] LAST = CNT_W'(WRITE_CYCLES - 1);
   localparam logic [CNT_W-1:0] HALF = CNT_W'(WRITE_CYCLES / 2);

   logic [7:0] cells [0:255];
   logic [CNT_W-1:0] cnt_r;
   logic busy_r;
   logic touch_r;
   logic [7:0] idx_r;
   logic [7:0] byte_r;

   // Cycle timer; a reset mid-cycle abandons the write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_r <= 1'b0;
         cnt_r <= '0;
      end else if (start && !busy_r) begin
         busy_r <= 1'b1;
         cnt_r <= '0;
      end else if (busy_r) begin
         if (cnt_r == LAST) begin
            busy_r <= 1'b0;
         end else begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end

   // Target location and value captured at start
   always_ff @(posedge clk) begin
      if (start && !busy_r) begin
         touch_r <= touch_array;
         idx_r <= wr_index;
         byte_r <= wr_byte;
      end
   end

   // Erase at mid-cycle, program on the last cycle
   always_ff @(posedge clk) begin
      if (busy_r && touch_r) begin
         if (cnt_r == LAST) begin
            cells[idx_r] <= byte_r;
         end else if (cnt_r == HALF) begin
            cells[idx_r] <= ERASED_BYTE;
         end
      end
   end

   // Final timer cycle and single-cycle read path
   assign done = busy_r && (cnt_r == LAST);
   assign rd_byte = cells[rd_index];

endmodule : nvac_cell_array

// >>> core/nvac_ctrl.sv
// Byte access control for the on-chip nonvolatile data array, register side.
// Assumes firmware drives the register port synchronously to clk, one access a cycle.
//
// Behaviour
// - With config select clear, program select picks data array or program memory.
// - Config select set sends accesses to configuration space regardless.
// - Writes run only with write permit set; permit clears on reset.
// - Abort flag sets when permit is set, clears when the write timer ends.
// - Abort flag reads one after reset or a bad write attempt.
// - A bad write attempt leaves both select bits as written for later tracing; reset clears them.
// - Writing one to write trigger starts a write; zero ignored; hardware clears it.
// - Completion sets the done flag in flag register two; software or reset clears it.
// - Read trigger ignored while program or config select is set.
// - Read trigger fetches the byte in one cycle and clears itself.
// - Data register holds the last read byte until read or written again.
// - Data register is eight bits; index register picks the byte.
// - Byte write erases the location first; the on-chip timer sets duration.
// - Row erase enable turns the next program-memory trigger into a row erase, then clears.
// - Unlock key register has no storage and reads zero.
// - Write starts only after keys 55h then AAh, then the trigger, per byte.
// - Trigger sets only if permit was already set by an earlier write.
// - Control, index and data registers are frozen while a write runs.
// - No write starts during the power-up lockout time.
module nvac_ctrl import nvac_pkg::*; #(
   parameter int unsigned WRITE_CYCLES = WRITE_CYC,
   parameter int unsigned PWRT_CYCLES = PWRT_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [2:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [TP_W-1:0] table_pointer,
   output logic [7:0] sfr_rdata,
   output logic [2:0] access_target,
   output logic write_busy,
   output logic prog_write_req,
   output logic row_erase_req,
   output logic [TP_W-1:0] prog_addr,
   output logic store_done_flag
);

   localparam logic [CNT_W-1:0] PWRT_LAST = CNT_W'(PWRT_CYCLES - 1);

   logic rst_meta_r;
   logic rst_n_r;
   logic pgm_r;
   logic cfg_r;
   logic row_r;
   logic abort_r;
   logic permit_r;
   logic wtrig_r;
   logic rtrig_r;
   logic [7:0] data_r;
   logic [7:0] index_r;
   logic done_flag_r;
   logic [CNT_W-1:0] pwrt_cnt_r;
   logic pwrt_done_r;
   logic [7:0] rdata_r;
   logic [2:0] target_r;
   logic prog_req_r;
   logic row_req_r;
   logic [TP_W-1:0] prog_addr_r;
   nvac_key_e key_r;
   nvac_key_e key_nxt;
   nvac_target_e tgt;
   logic [7:0] rd_byte;
   logic done;
   logic ctrl_wr;
   logic ctrl_ok;
   logic key_wr;
   logic start;
   logic bad_try;
   logic permit_rise;
   logic rd_go;
   logic [7:0] ctrl_byte;
   logic [7:0] rd_mux;

   // Reset release through two flip-flops
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   // Register port decode and write qualification
   assign tgt = nvac_target(pgm_r, cfg_r);
   assign ctrl_wr = sfr_wr && (sfr_addr == REG_CTRL);
   assign ctrl_ok = ctrl_wr && !wtrig_r;
   assign key_wr = sfr_wr && (sfr_addr == REG_KEY);
   assign start = ctrl_ok && sfr_wdata[B_WTRIG] && permit_r
      && (key_r == KEY_ARMED) && pwrt_done_r;
   assign bad_try = ctrl_ok && sfr_wdata[B_WTRIG] && !start;
   assign permit_rise = ctrl_ok && sfr_wdata[B_PERMIT] && !permit_r;
   assign rd_go = ctrl_ok && sfr_wdata[B_RTRIG] && !pgm_r && !cfg_r;

   // Select bits change only by software or reset, not by the abort logic
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pgm_r <= RST_SEL;
         cfg_r <= RST_SEL;
      end else if (ctrl_ok) begin
         pgm_r <= sfr_wdata[B_PGM];
         cfg_r <= sfr_wdata[B_CFG];
      end
   end

   // Row erase enable, cleared by completion of a program-memory cycle
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         row_r <= 1'b0;
      end else if (done && (tgt == TGT_PROG)) begin
         row_r <= 1'b0;
      end else if (ctrl_ok) begin
         row_r <= sfr_wdata[B_ROW];
      end
   end

   // Write permit, cleared only by reset or software
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         permit_r <= RST_PERMIT;
      end else if (ctrl_ok) begin
         permit_r <= sfr_wdata[B_PERMIT];
      end
   end

   // Abort flag: reset reads one, hardware set beats clear
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         abort_r <= RST_ABORT;
      end else if (permit_rise || bad_try) begin
         abort_r <= 1'b1;
      end else if (done) begin
         abort_r <= 1'b0;
      end else if (ctrl_ok) begin
         abort_r <= sfr_wdata[B_ABORT];
      end
   end

   // Write trigger held for the whole self-timed cycle
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         wtrig_r <= 1'b0;
      end else if (start) begin
         wtrig_r <= 1'b1;
      end else if (done) begin
         wtrig_r <= 1'b0;
      end
   end

   // Read trigger reads as one for the single read cycle
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rtrig_r <= 1'b0;
      end else begin
         rtrig_r <= rd_go;
      end
   end

   // Data register: loaded by a read or by software when idle
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         data_r <= ZERO_BYTE;
      end else if (rd_go) begin
         data_r <= rd_byte;
      end else if (sfr_wr && (sfr_addr == REG_DATA) && !wtrig_r) begin
         data_r <= sfr_wdata;
      end
   end

   // Byte index register
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         index_r <= ZERO_BYTE;
      end else if (sfr_wr && (sfr_addr == REG_INDEX) && !wtrig_r) begin
         index_r <= sfr_wdata;
      end
   end

   // Unlock key sequence; any trigger attempt consumes it
   always_comb begin
      key_nxt = key_r;
      if (ctrl_wr && sfr_wdata[B_WTRIG]) begin
         key_nxt = KEY_IDLE;
      end else if (key_wr) begin
         case (key_r)
            KEY_HALF: begin
               key_nxt = (sfr_wdata == KEY_SECOND) ? KEY_ARMED : KEY_IDLE;
            end
            KEY_IDLE, KEY_ARMED: begin
               key_nxt = (sfr_wdata == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
            end
            default: begin
               key_nxt = KEY_IDLE;
            end
         endcase
         if (sfr_wdata == KEY_FIRST) begin
            key_nxt = KEY_HALF;
         end
      end
   end

   // Key state register
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         key_r <= KEY_IDLE;
      end else begin
         key_r <= key_nxt;
      end
   end

   // Done flag in flag register two; completion wins over a clear
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         done_flag_r <= 1'b0;
      end else if (done) begin
         done_flag_r <= 1'b1;
      end else if (sfr_wr && (sfr_addr == REG_FLAG2)) begin
         done_flag_r <= sfr_wdata[B_DONE];
      end
   end

   // Power-up lockout timer
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pwrt_cnt_r <= '0;
         pwrt_done_r <= 1'b0;
      end else if (!pwrt_done_r) begin
         if (pwrt_cnt_r == PWRT_LAST) begin
            pwrt_done_r <= 1'b1;
         end else begin
            pwrt_cnt_r <= pwrt_cnt_r + 1'b1;
         end
      end
   end

   // Requests to program or configuration space
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         target_r <= TGT_DATA;
         prog_req_r <= 1'b0;
         row_req_r <= 1'b0;
         prog_addr_r <= '0;
      end else begin
         target_r <= tgt;
         prog_req_r <= start && (tgt != TGT_DATA) && !(row_r && (tgt == TGT_PROG));
         row_req_r <= start && row_r && (tgt == TGT_PROG);
         if (start) begin
            prog_addr_r <= table_pointer;
         end
      end
   end

   // Read-back multiplexer; key and unmapped selects read zero
   assign ctrl_byte = {pgm_r, cfg_r, 1'b0, row_r, abort_r, permit_r, wtrig_r, rtrig_r};
   always_comb begin
      case (sfr_addr)
         REG_CTRL: rd_mux = ctrl_byte;
         REG_DATA: rd_mux = data_r;
         REG_INDEX: rd_mux = index_r;
         REG_FLAG2: rd_mux = {3'h0, done_flag_r, 4'h0};
         default: rd_mux = ZERO_BYTE;
      endcase
   end

   // Registered read data, updated on each read strobe
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rdata_r <= ZERO_BYTE;
      end else if (sfr_rd) begin
         rdata_r <= rd_mux;
      end
   end

   // Cell array and its write timer
   nvac_cell_array #(
      .WRITE_CYCLES(WRITE_CYCLES)
   ) u_cells (
      .clk(clk),
      .rst_n(rst_n_r),
      .start(start),
      .touch_array(tgt == TGT_DATA),
      .wr_index(index_r),
      .wr_byte(data_r),
      .rd_index(index_r),
      .rd_byte(rd_byte),
      .done(done)
   );

   // Outputs, each straight from a flip-flop
   assign sfr_rdata = rdata_r;
   assign access_target = target_r;
   assign write_busy = wtrig_r;
   assign prog_write_req = prog_req_r;
   assign row_erase_req = row_req_r;
   assign prog_addr = prog_addr_r;
   assign store_done_flag = done_flag_r;

   // Checks on the register behaviour
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n_r);

   sequence s_read_cycle;
      rtrig_r ##1 !rtrig_r;
   endsequence

   // Key pair with one idle cycle between, so no stray key write can slip in
   sequence s_key_pair;
      (key_wr && sfr_wdata == KEY_FIRST) ##1 !sfr_wr ##1 (key_wr && sfr_wdata == KEY_SECOND);
   endsequence

   a_read_one_cycle: assert property (rd_go |=> s_read_cycle and (data_r == $past(rd_byte)))
      else $error("read trigger or fetched byte wrong");
   a_read_space_block: assert property (ctrl_ok && sfr_wdata[B_RTRIG]
      && (pgm_r || cfg_r) |=> !rtrig_r && $stable(data_r))
      else $error("read started outside data space");
   a_trig_needs_permit: assert property ($rose(wtrig_r) |-> $past(permit_r, 1) && $past(permit_r, 2))
      else $error("write trigger set without earlier permit");
   a_trig_needs_key: assert property ($rose(wtrig_r) |-> $past(key_r) == KEY_ARMED)
      else $error("write trigger set without unlock keys");
   a_key_then_trig: assert property (s_key_pair ##1 !sfr_wr ##1 (ctrl_wr
      && sfr_wdata[B_WTRIG] && permit_r && pwrt_done_r && !wtrig_r) |=> wtrig_r)
      else $error("keyed trigger did not start a write");
   a_done_sets_flag: assert property (done |=> done_flag_r && !wtrig_r && !abort_r)
      else $error("completion did not update flags");
   a_abort_on_permit: assert property (permit_rise |=> abort_r && permit_r)
      else $error("permit set without abort flag");
   a_busy_holds_regs: assert property (wtrig_r && $past(wtrig_r)
      |-> $stable(index_r) && $stable(data_r) && $stable(pgm_r) && $stable(permit_r))
      else $error("registers changed during write");
   a_key_reads_zero: assert property (sfr_rd && sfr_addr == REG_KEY |=> sfr_rdata == ZERO_BYTE)
      else $error("key register read nonzero");
   a_lockout_blocks: assert property (!pwrt_done_r |=> !wtrig_r)
      else $error("write started during power-up lockout");
   a_select_traced: assert property (bad_try |=> abort_r
      && pgm_r == $past(sfr_wdata[B_PGM]) && cfg_r == $past(sfr_wdata[B_CFG]))
      else $error("select bits changed on abort");
   a_target_decode: assert property (cfg_r |=> access_target == TGT_CFG)
      else $error("config select not routed to config space");

endmodule : nvac_ctrl

// >>> test/nvac_ctrl_test.sv
// Self-checking bench for the nonvolatile byte access control, driving its register port.
// Assumes short write and lockout counts and a 50 MHz clock; inputs change on falling edges.
module nvac_ctrl_test import nvac_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned WCYC = 8;
   localparam int unsigned PCYC = 4;
   logic clk;
   logic arst_n;
   logic [2:0] sfr_addr;
   logic sfr_wr;
   logic sfr_rd;
   logic [7:0] sfr_wdata;
   logic [TP_W-1:0] table_pointer;
   logic [7:0] sfr_rdata;
   logic [2:0] access_target;
   logic write_busy;
   logic prog_write_req;
   logic row_erase_req;
   logic [TP_W-1:0] prog_addr;
   logic store_done_flag;
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int row_pulses = 0;
   int prog_pulses = 0;

   nvac_ctrl #(.WRITE_CYCLES(WCYC), .PWRT_CYCLES(PCYC)) dut_u (
      .clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .table_pointer(table_pointer), .sfr_rdata(sfr_rdata),
      .access_target(access_target), .write_busy(write_busy), .prog_write_req(prog_write_req),
      .row_erase_req(row_erase_req), .prog_addr(prog_addr), .store_done_flag(store_done_flag)
   );

   // Clock generation
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Pulse counters and hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (row_erase_req === 1'b1) row_pulses <= row_pulses + 1;
      if (prog_write_req === 1'b1) prog_pulses <= prog_pulses + 1;
      if (cycles == 3000) begin
         num_errors = num_errors + 1;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // One register write, strobe held for exactly one rising edge
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      d = sfr_rdata;
   endtask : rd

   task automatic keyed_trigger(input logic [7:0] c);
      wr(REG_KEY, KEY_FIRST);
      wr(REG_KEY, KEY_SECOND);
      wr(REG_CTRL, c);
   endtask : keyed_trigger

   // Waits out a running write and returns its length in cycles
   task automatic wait_idle(output int n);
      n = 0;
      while (write_busy === 1'b1 && n < 100) begin
         n++;
         @(negedge clk);
      end
   endtask : wait_idle

   task automatic test_reset_state();
      logic [7:0] d;
      rd(REG_CTRL, d);
      chk("ctrl after reset", 8'h08, d);
      rd(REG_KEY, d);
      chk("key readback", 8'h00, d);
      rd(3'h6, d);
      chk("unmapped read", 8'h00, d);
      chk("target after reset", TGT_DATA, access_target);
   endtask : test_reset_state

   task automatic test_bad_trigger();
      logic [7:0] d;
      wr(REG_CTRL, 8'h06);
      @(negedge clk);
      chk("busy same-write permit", 1'b0, write_busy);
      wr(REG_CTRL, 8'h00);
      keyed_trigger(8'h02);
      @(negedge clk);
      chk("busy without permit", 1'b0, write_busy);
      rd(REG_CTRL, d);
      chk("ctrl after refused", 8'h08, d);
   endtask : test_bad_trigger

   task automatic test_data_write();
      logic [7:0] d;
      int n;
      wr(REG_INDEX, 8'h3C);
      wr(REG_DATA, 8'hA5);
      wr(REG_CTRL, 8'h04);
      rd(REG_CTRL, d);
      chk("abort on permit", 8'h0C, d);
      keyed_trigger(8'h06);
      chk("busy after trigger", 1'b1, write_busy);
      wait_idle(n);
      chk("write length", WCYC, n);
      chk("done flag", 1'b1, store_done_flag);
      rd(REG_CTRL, d);
      chk("ctrl after write", 8'h04, d);
      rd(REG_FLAG2, d);
      chk("flag two set", 8'h10, d);
      wr(REG_FLAG2, 8'h00);
      chk("done cleared", 1'b0, store_done_flag);
   endtask : test_data_write

   task automatic test_read_and_select();
      logic [7:0] d;
      wr(REG_DATA, 8'h00);
      wr(REG_CTRL, 8'h01);
      rd(REG_DATA, d);
      chk("read back byte", 8'hA5, d);
      rd(REG_CTRL, d);
      chk("read trigger self-clears", 8'h00, d);
      wr(REG_DATA, 8'h11);
      // Select first, then try the read, so only the select bit can refuse it
      wr(REG_CTRL, 8'h80);
      wr(REG_CTRL, 8'h81);
      @(negedge clk);
      chk("target program", TGT_PROG, access_target);
      rd(REG_DATA, d);
      chk("read refused program", 8'h11, d);
      wr(REG_CTRL, 8'h40);
      wr(REG_CTRL, 8'h41);
      @(negedge clk);
      chk("target config", TGT_CFG, access_target);
      rd(REG_DATA, d);
      chk("read refused config", 8'h11, d);
      rd(REG_CTRL, d);
      chk("read trigger refused", 8'h40, d);
      wr(REG_CTRL, 8'hC0);
      @(negedge clk);
      chk("config over program", TGT_CFG, access_target);
   endtask : test_read_and_select

   task automatic test_row_erase();
      logic [7:0] d;
      int n;
      table_pointer = 22'h2ABCDE;
      wr(REG_CTRL, 8'h94);
      keyed_trigger(8'h96);
      wr(REG_CTRL, 8'h00);
      wr(REG_INDEX, 8'h77);
      wait_idle(n);
      chk("row erase pulses", 1, row_pulses);
      chk("no plain write pulse", 0, prog_pulses);
      chk("captured pointer", 22'h2ABCDE, prog_addr);
      rd(REG_CTRL, d);
      chk("row bit cleared", 8'h84, d);
      rd(REG_INDEX, d);
      chk("index frozen", 8'h3C, d);
      wr(REG_CTRL, 8'h86);
      @(negedge clk);
      chk("no keys no write", 1'b0, write_busy);
      rd(REG_CTRL, d);
      chk("selects kept on abort", 8'h8C, d);
      // Row erase bit now clear, so the next keyed trigger is a plain program write
      keyed_trigger(8'h86);
      wait_idle(n);
      chk("plain write pulse", 1, prog_pulses);
      chk("no second row erase", 1, row_pulses);
   endtask : test_row_erase

   // Reset in mid-write: abort reads one and the old byte survives
   task automatic test_reset_mid_write();
      logic [7:0] d;
      wr(REG_CTRL, 8'h04);
      keyed_trigger(8'h06);
      repeat (2) @(negedge clk);
      arst_n = 1'b0;
      @(negedge clk);
      arst_n = 1'b1;
      repeat (PCYC + 4) @(negedge clk);
      chk("busy after reset", 1'b0, write_busy);
      rd(REG_CTRL, d);
      chk("abort after cut write", 8'h08, d);
      wr(REG_INDEX, 8'h3C);
      wr(REG_CTRL, 8'h01);
      rd(REG_DATA, d);
      chk("cut write left byte", 8'hA5, d);
   endtask : test_reset_mid_write

   // Main sequence
   initial begin
      arst_n = 1'b0;
      sfr_addr = 3'h0;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_wdata = 8'h00;
      table_pointer = '0;
      repeat (5) @(negedge clk);
      arst_n = 1'b1;
      repeat (PCYC + 4) @(negedge clk);
      test_reset_state();
      test_bad_trigger();
      test_data_write();
      test_read_and_select();
      test_row_erase();
      test_reset_mid_write();
      wrap_up();
   end
endmodule : nvac_ctrl_test
